// ---- hdl/crhp_buf2.sv ----
// Purpose: two-entry word buffer between column store and processor
// Assumes: one push and one pop per cycle at most
// Notes:   flush empties it in one cycle
`timescale 1ns/1ps
module crhp_buf2 import crhp_pkg::*; #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem [2];
  logic [1:0]       count;
  logic [1:0]       next_count;
  logic             wp;
  logic             next_wp;
  logic             rp;
  logic             next_rp;
  logic             push;
  logic             pop;

  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = mem[rp];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  always_comb begin
    next_count = count;
    next_wp    = wp;
    next_rp    = rp;
    if (flush) begin
      next_count = 2'd0;
      next_wp    = 1'b0;
      next_rp    = 1'b0;
    end else begin
      if (push) next_wp = ~wp;
      if (pop) next_rp = ~rp;
      if (push & ~pop) next_count = count + 2'd1;
      else if (pop & ~push) next_count = count - 2'd1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 2'd0;
      wp    <= 1'b0;
      rp    <= 1'b0;
    end else begin
      count <= next_count;
      wp    <= next_wp;
      rp    <= next_rp;
    end
  end

  // storage only; no reset needed on the data path
  always_ff @(posedge ref_clk) begin
    if (push) mem[wp] <= in_data;
  end

  AST_BUF_NO_OVERFILL: assert property (@(posedge ref_clk) disable iff (!nrst)
    count == 2'd2 && !pop |=> count == 2'd2 || $past(flush))
    else $error("buffer lost an entry");

endmodule : crhp_buf2

// ---- hdl/crhp_cfg.svh ----
// Purpose: bit positions, reset values and counts of the card port
// Assumes: word bit 1 is the msb [15], word bit 16 the lsb [0]
// Notes:   definitions only
`ifndef CRHP_CFG_SVH
`define CRHP_CFG_SVH

// ==========================================================
// command word fields (word bits 12..16)
`define CRHP_CMD_IRQ_ALLOW  4
`define CRHP_CMD_RAW_READ   3
`define CRHP_CMD_CLEAR      2
`define CRHP_CMD_CODED_READ 1
`define CRHP_CMD_TERMINATE  0

// ==========================================================
// condition word fields
`define CRHP_STAT_DATA_REQ  15
`define CRHP_STAT_TROUBLE   2
`define CRHP_STAT_READY     0

// ==========================================================
// coded character word fields
`define CRHP_NORM_CHECK     15
`define CRHP_NORM_ZERO_HI   14
`define CRHP_NORM_ZERO_LO   8

// ==========================================================
// counts and reset values
`define CRHP_COLUMNS        7'd80
`define CRHP_LAST_COLUMN    7'd79
`define CRHP_COL_ZERO       7'd0
`define CRHP_WORD_RESET     16'h0000
`define CRHP_SYNC_RESET     16'h0000

`endif

// ---- hdl/crhp_pkg.sv ----
// Purpose: types shared by the card port files
// Assumes: crhp_cfg.svh holds the numbers
// Notes:   request and answer travel as packed structs
package crhp_pkg;

  // ==========================================================
  // port select unit request and answer
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        instr;
    logic [15:0] data;
  } crhp_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } crhp_ans_t;

  // ==========================================================
  // read cycle states and modes
  typedef enum logic [1:0] {CRHP_IDLE, CRHP_LOAD, CRHP_XFER} crhp_state_t;
  typedef enum logic {CRHP_RAW, CRHP_CODED} crhp_mode_t;

endpackage : crhp_pkg

// ---- hdl/crhp_port.sv ----
// Purpose: card reader port logic facing the processor's port select unit
// Assumes: processor strobes share ref_clk; reader lines are asynchronous
// Notes:   80 columns stored, handed out through a two-entry buffer
// ==========================================================
`timescale 1ns/1ps
`include "crhp_cfg.svh"
module crhp_port import crhp_pkg::*; (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // port select unit side
  input  wire crhp_req_t   req,
  input  wire logic        sys_clear,
  output crhp_ans_t        ans,
  output logic             data_irq,
  output logic             status_irq,
  // reader side, asynchronous
  input  wire logic [11:0] row_lines,
  input  wire logic        col_strobe,
  input  wire logic        start_sw,
  input  wire logic        rdr_ready,
  input  wire logic        read_check,
  output logic             start_card_cycle
);
  // ==========================================================
  // reader input synchroniser
  logic [15:0] sync1;
  logic [15:0] sync2;
  logic [2:0]  prev;
  logic [11:0] s_rows;
  logic        s_strobe;
  logic        s_start;
  logic        s_ready;
  logic        s_check;
  logic        strobe_rise;
  logic        start_rise;
  logic        ready_fall;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= `CRHP_SYNC_RESET;
      sync2 <= `CRHP_SYNC_RESET;
      prev  <= 3'h0;
    end else begin
      sync1 <= {row_lines, col_strobe, start_sw, rdr_ready, read_check};
      sync2 <= sync1;
      prev  <= {s_strobe, s_start, s_ready};
    end
  end

  assign {s_rows, s_strobe, s_start, s_ready, s_check} = sync2;
  assign strobe_rise = s_strobe & ~prev[2];
  assign start_rise  = s_start & ~prev[1];
  assign ready_fall  = ~s_ready & prev[0];

  // ==========================================================
  // word formatting
  function automatic logic [15:0] fmt_raw(input logic [11:0] r);
    fmt_raw = {4'h0, r};
  endfunction : fmt_raw

  function automatic logic [15:0] fmt_coded(input logic [11:0] r);
    logic [2:0] num;
    logic [2:0] holes;
    num   = 3'h0;
    holes = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (r[i]) begin
        num   = 3'(i + 1);
        holes = holes + 3'h1;
      end
    end
    fmt_coded = {(holes > 3'h1), 7'h00, r[11:7], num};
  endfunction : fmt_coded

  // ==========================================================
  // request decode
  logic        cmd_wr;
  logic        stat_rd;
  logic        data_rd;
  logic        cancel;
  logic        start_req;
  logic        term;
  crhp_state_t state;
  crhp_state_t next_state;

  assign cmd_wr    = req.wr & req.instr;
  assign stat_rd   = req.rd & req.instr;
  assign data_rd   = req.rd & ~req.instr;
  assign cancel    = (cmd_wr & req.data[`CRHP_CMD_CLEAR]) | sys_clear;
  assign start_req = cmd_wr & ~cancel & (state == CRHP_IDLE)
                   & (req.data[`CRHP_CMD_RAW_READ] | req.data[`CRHP_CMD_CODED_READ]);
  assign term      = cmd_wr & req.data[`CRHP_CMD_TERMINATE] & (state == CRHP_XFER);

  // ==========================================================
  // column store and read cycle
  logic [11:0] col_mem [80];
  crhp_mode_t  mode;
  crhp_mode_t  next_mode;
  logic [6:0]  wr_col;
  logic [6:0]  next_wr_col;
  logic [6:0]  rd_col;
  logic [6:0]  next_rd_col;
  logic        chk_seen;
  logic        next_chk_seen;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic [15:0] buf_out_data;
  logic        push;
  logic [15:0] push_word;
  logic        load_done;
  logic        flush;

  assign load_done = (state == CRHP_LOAD) & strobe_rise & (wr_col == `CRHP_LAST_COLUMN);
  assign push      = (state == CRHP_XFER) & (rd_col != `CRHP_COLUMNS) & ~cancel & ~term;
  assign push_word = (mode == CRHP_RAW) ? fmt_raw(col_mem[rd_col]) : fmt_coded(col_mem[rd_col]);
  assign flush     = cancel | term;

  always_comb begin
    next_state    = state;
    next_mode     = mode;
    next_wr_col   = wr_col;
    next_rd_col   = rd_col;
    next_chk_seen = chk_seen;
    unique case (state)
      CRHP_IDLE: begin
        if (start_req) begin
          next_state    = CRHP_LOAD;
          // bit 13 wins if both read bits are set
          next_mode     = req.data[`CRHP_CMD_RAW_READ] ? CRHP_RAW : CRHP_CODED;
          next_wr_col   = `CRHP_COL_ZERO;
          next_chk_seen = 1'b0;
        end
      end
      CRHP_LOAD: begin
        if (s_check) next_chk_seen = 1'b1;
        if (strobe_rise) next_wr_col = wr_col + 7'd1;
        if (load_done) begin
          next_state  = CRHP_XFER;
          next_rd_col = `CRHP_COL_ZERO;
        end
      end
      CRHP_XFER: begin
        if (push & buf_in_ready) next_rd_col = rd_col + 7'd1;
        if ((rd_col == `CRHP_COLUMNS) & ~buf_out_valid) next_state = CRHP_IDLE;
      end
    endcase
    if (cancel & (state != CRHP_IDLE)) begin
      next_state  = CRHP_IDLE;
      next_rd_col = `CRHP_COL_ZERO;
    end
    if (term) begin
      next_state  = CRHP_IDLE;
      next_rd_col = `CRHP_COL_ZERO;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state    <= CRHP_IDLE;
      mode     <= CRHP_RAW;
      wr_col   <= `CRHP_COL_ZERO;
      rd_col   <= `CRHP_COL_ZERO;
      chk_seen <= 1'b0;
    end else begin
      state    <= next_state;
      mode     <= next_mode;
      wr_col   <= next_wr_col;
      rd_col   <= next_rd_col;
      chk_seen <= next_chk_seen;
    end
  end

  always_ff @(posedge ref_clk) begin
    if ((state == CRHP_LOAD) & strobe_rise) col_mem[wr_col] <= s_rows;
  end

  // a stalled processor leaves words parked here, the store pointer waits
  crhp_buf2 #(.WIDTH(16)) u_buf (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .flush     (flush),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (push_word),
    .out_valid (buf_out_valid),
    .out_ready (data_rd),
    .out_data  (buf_out_data)
  );

  // ==========================================================
  // enable, ready, trouble and interrupts
  logic irq_allow;
  logic next_irq_allow;
  logic ready;
  logic next_ready;
  logic trouble;
  logic next_trouble;
  logic start_pend;
  logic next_start_pend;
  logic stat_pend;
  logic next_stat_pend;
  logic next_data_irq;
  logic next_status_irq;
  logic next_start_card_cycle;
  logic bad_card;

  assign bad_card = chk_seen | s_check;

  always_comb begin
    next_irq_allow  = irq_allow;
    next_ready      = ready;
    next_trouble    = trouble;
    next_start_pend = start_pend;
    next_stat_pend  = stat_pend;
    if (cmd_wr) next_irq_allow = req.data[`CRHP_CMD_IRQ_ALLOW];
    if (sys_clear) next_irq_allow = 1'b0;
    if (stat_rd) next_stat_pend = 1'b0;
    if (ready_fall) begin
      next_ready      = 1'b0;
      next_start_pend = 1'b0;
      // a drop must not wipe an event that is still pending
      if (ready) next_stat_pend = 1'b1;
    end
    if (start_rise) begin
      // operator action also clears trouble
      next_trouble = 1'b0;
      if (s_ready & ~ready) begin
        if (irq_allow) begin
          next_ready     = 1'b1;
          next_stat_pend = 1'b1;
        end else begin
          next_start_pend = 1'b1;
        end
      end
    end
    if (start_pend & cmd_wr & req.data[`CRHP_CMD_IRQ_ALLOW] & s_ready) begin
      next_ready      = 1'b1;
      next_start_pend = 1'b0;
      next_stat_pend  = 1'b1;
    end
    // a read command outranks any ready set in the same cycle
    if (start_req) next_ready = 1'b0;
    if (load_done) begin
      if (bad_card) begin
        next_trouble   = 1'b1;
        next_stat_pend = 1'b1;
      end else if (s_ready & ~trouble) begin
        next_ready = 1'b1;
      end
    end
    next_status_irq       = next_stat_pend & next_irq_allow;
    // buffer holds a word after this edge: one pushed, or one left after any pop
    next_data_irq         = ~flush & next_irq_allow & (state == CRHP_XFER)
                          & ((push & buf_in_ready) | (buf_out_valid & ~(data_rd & buf_in_ready)));
    next_start_card_cycle = (next_state == CRHP_LOAD);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_allow        <= 1'b0;
      ready            <= 1'b0;
      trouble          <= 1'b0;
      start_pend       <= 1'b0;
      stat_pend        <= 1'b0;
      status_irq       <= 1'b0;
      data_irq         <= 1'b0;
      start_card_cycle <= 1'b0;
    end else begin
      irq_allow        <= next_irq_allow;
      ready            <= next_ready;
      trouble          <= next_trouble;
      start_pend       <= next_start_pend;
      stat_pend        <= next_stat_pend;
      status_irq       <= next_status_irq;
      data_irq         <= next_data_irq;
      start_card_cycle <= next_start_card_cycle;
    end
  end

  // ==========================================================
  // answer to reads
  crhp_ans_t next_ans;

  always_comb begin
    next_ans.valid = stat_rd | data_rd;
    next_ans.data  = `CRHP_WORD_RESET;
    if (stat_rd) begin
      next_ans.data[`CRHP_STAT_DATA_REQ] = data_irq;
      next_ans.data[`CRHP_STAT_TROUBLE]  = trouble;
      next_ans.data[`CRHP_STAT_READY]    = ready;
    end else if (data_rd & buf_out_valid) begin
      next_ans.data = buf_out_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ans <= '0;
    end else begin
      ans <= next_ans;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_terminated;
    (state == CRHP_IDLE) && (rd_col == `CRHP_COL_ZERO) && !data_irq;
  endsequence

  sequence s_stays_quiet;
    !data_irq [*3];
  endsequence

  AST_IRQ_NEEDS_ALLOW: assert property (status_irq |-> irq_allow)
    else $error("status interrupt without enable");
  AST_DATA_IRQ_GATED: assert property (!irq_allow |-> !data_irq)
    else $error("data interrupt without enable");
  AST_ALLOW_CLEARED: assert property ((cmd_wr && !req.data[`CRHP_CMD_IRQ_ALLOW]) || sys_clear |=> !irq_allow)
    else $error("enable not cleared");
  AST_BUSY_IGNORES: assert property (state != CRHP_IDLE && cmd_wr |=> $stable(mode) && state != CRHP_LOAD || $past(state) == CRHP_LOAD)
    else $error("read honored during cycle");
  AST_CLEAR_CANCELS: assert property (cmd_wr && req.data[`CRHP_CMD_CLEAR] |=> state == CRHP_IDLE)
    else $error("clear did not cancel");
  AST_TERMINATE: assert property (term |=> s_terminated ##0 s_stays_quiet)
    else $error("terminate not honored");
  AST_RAW_FORMAT: assert property (push && mode == CRHP_RAW |-> push_word[15:12] == 4'h0)
    else $error("raw word upper bits set");
  AST_CODED_FORMAT: assert property (push && mode == CRHP_CODED |-> push_word[14:8] == 7'h00)
    else $error("coded word unused bits set");
  AST_STATUS_ANSWER: assert property (stat_rd |=> ans.valid && ans.data[`CRHP_STAT_READY] == $past(ready))
    else $error("status answer wrong");
  AST_READY_DROPS: assert property (start_req |=> !ready)
    else $error("ready kept after read command");

endmodule : crhp_port

// ---- test/crhp_reader_model.sv ----
// Purpose: card reader stand-in driving row lines and column strobes
// Assumes: rows settle 3 cycles (6 when slow) before a strobe and hold 3 after it
// Notes:   stops between columns once the port drops start_card_cycle
`timescale 1ns/1ps
module crhp_reader_model (
  // clock and control
  input  wire logic   ref_clk,
  input  wire logic   start_card_cycle,
  input  wire logic   slow,
  // reader lines
  output logic [11:0] row_lines,
  output logic        col_strobe
);
  int col;

  // ==========================================================
  // column pattern: single holes, a blank, a multi-punch
  function automatic logic [11:0] pat(input int c);
    logic [6:0] lo;
    lo = (c % 9 < 7) ? 7'(1 << (c % 9)) : ((c % 9 == 7) ? 7'h00 : 7'h41);
    return {5'(c * 7 + 3), lo};
  endfunction : pat

  // ==========================================================
  // card cycle, column 1 first
  initial begin
    row_lines  = 12'hA5A;
    col_strobe = 1'b0;
    forever begin
      @(negedge ref_clk);
      for (col = 0; col < 80 && start_card_cycle === 1'b1; col++) begin
        row_lines = pat(col);
        repeat (slow ? 6 : 3) @(negedge ref_clk);
        col_strobe = 1'b1;
        repeat (3) @(negedge ref_clk);
        col_strobe = 1'b0;
        repeat (3) @(negedge ref_clk);
        // stale rows inverted so a late sample cannot pass
        row_lines = ~row_lines;
        @(negedge ref_clk);
      end
      while (start_card_cycle === 1'b1) @(negedge ref_clk);
    end
  end
endmodule : crhp_reader_model

// ---- test/tb.sv ----
// Purpose: self-checking bench for the card reader port
// Assumes: requests driven at the falling edge, one cycle each
// Notes:   raw, coded, terminate, clear and system clear cases
`timescale 1ns/1ps
module tb import crhp_pkg::*; ();
  logic        ref_clk, nrst, sys_clear, start_sw, rdr_ready, read_check;
  logic        slow, data_irq, status_irq, start_card_cycle, col_strobe;
  logic [11:0] row_lines;
  logic [15:0] v;
  crhp_req_t   req;
  crhp_ans_t   ans;
  int          mismatches, compares, c;

  crhp_port u_dut (.ref_clk(ref_clk), .nrst(nrst), .req(req), .sys_clear(sys_clear),
    .ans(ans), .data_irq(data_irq), .status_irq(status_irq), .row_lines(row_lines),
    .col_strobe(col_strobe), .start_sw(start_sw), .rdr_ready(rdr_ready),
    .read_check(read_check), .start_card_cycle(start_card_cycle));

  crhp_reader_model u_rdr (.ref_clk(ref_clk), .start_card_cycle(start_card_cycle),
    .slow(slow), .row_lines(row_lines), .col_strobe(col_strobe));

  // ==========================================================
  // helpers
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task final_report();
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task put(input logic wr, input logic rd, input logic instr, input logic [15:0] d);
    @(negedge ref_clk);
    req = '{wr, rd, instr, d};
    @(negedge ref_clk);
    req = '0;
  endtask : put

  task cmd(input logic [15:0] d);
    put(1'b1, 1'b0, 1'b1, d);
  endtask : cmd

  task rd(input logic instr, output logic [15:0] r);
    put(1'b0, 1'b1, instr, 16'h0000);
    if (ans.valid !== 1'b1) @(negedge ref_clk);
    r = (ans.valid === 1'b1) ? ans.data : 16'hXXXX;
  endtask : rd

  task flag(input logic f, input logic e);
    check({15'h0000, f}, {15'h0000, e});
  endtask : flag

  task wait_irq(input int lim);
    int i;
    for (i = 0; i < lim && data_irq !== 1'b1; i++) @(negedge ref_clk);
    if (data_irq !== 1'b1) begin
      flag(data_irq, 1'b1);
      final_report();
    end
  endtask : wait_irq

  // word bit 1 is data[15], bit 16 is data[0]
  function automatic logic [15:0] coded(input logic [11:0] r);
    logic [2:0] hi;
    int         n;
    hi = 3'h0;
    n  = 0;
    for (int k = 0; k < 7; k++) begin
      if (r[k]) begin
        hi = 3'(k + 1);
        n++;
      end
    end
    return {n > 1, 7'h00, r[11], r[10], r[9], r[8], r[7], hi};
  endfunction : coded

  // ==========================================================
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (60000) @(negedge ref_clk);
    check(16'h0001, 16'h0000);
    final_report();
  end

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0; req = '0; sys_clear = 1'b0; start_sw = 1'b0;
    rdr_ready = 1'b1; read_check = 1'b0; slow = 1'b0;
    mismatches = 0; compares = 0;
    cyc(6);
    nrst = 1'b1;
    rd(1'b1, v); check(v, 16'h0000);
    rd(1'b0, v); check(v, 16'h0000);
    start_sw = 1'b1; cyc(4); start_sw = 1'b0; cyc(4);
    rd(1'b1, v); check(v, 16'h0000);
    flag(status_irq, 1'b0);
    cmd(16'h0010); cyc(4);
    flag(status_irq, 1'b1);
    rd(1'b1, v); check(v, 16'h0001);
    flag(status_irq, 1'b0);
    put(1'b1, 1'b0, 1'b0, 16'h0018); cyc(3);
    flag(start_card_cycle, 1'b0);
    cmd(16'h001E); cyc(3);
    flag(start_card_cycle, 1'b0);
    // raw card with junk in ignored command bits
    cmd(16'hABD8); cyc(2);
    flag(start_card_cycle, 1'b1);
    rd(1'b1, v); check(v, 16'h0000);
    cmd(16'h0012);
    cmd(16'h0011);
    wait_irq(2000);
    for (c = 0; c < 80; c++) begin
      if (c == 5) begin
        cmd(16'h0000); cyc(4);
        flag(data_irq, 1'b0);
        cmd(16'h0010); cyc(4);
        flag(data_irq, 1'b1);
        rd(1'b1, v); check(v, 16'h8001);
      end
      rd(1'b0, v); check(v, {4'h0, u_rdr.pat(c)});
    end
    cyc(4);
    flag(data_irq, 1'b0);
    rd(1'b0, v); check(v, 16'h0000);
    rd(1'b1, v); check(v, 16'h0001);
    // coded card, slow reader, read error during the card
    slow = 1'b1; read_check = 1'b1;
    cmd(16'h0012); cyc(20);
    read_check = 1'b0;
    wait_irq(3000);
    for (c = 0; c < 10; c++) begin
      rd(1'b0, v); check(v, coded(u_rdr.pat(c)));
    end
    rd(1'b1, v); check(v, 16'h8004);
    cmd(16'h0011); cyc(4);
    flag(data_irq, 1'b0);
    rd(1'b0, v); check(v, 16'h0000);
    rd(1'b1, v); check(v, 16'h0004);
    // clear and system clear in mid-card
    slow = 1'b0;
    cmd(16'h0018); cyc(100);
    cmd(16'h0014); cyc(3);
    flag(start_card_cycle, 1'b0);
    cyc(30);
    flag(data_irq, 1'b0);
    cmd(16'h0018); cyc(100);
    sys_clear = 1'b1; cyc(1); sys_clear = 1'b0; cyc(3);
    flag(start_card_cycle, 1'b0);
    cyc(30);
    start_sw = 1'b1; cyc(4); start_sw = 1'b0; cyc(4);
    rd(1'b1, v); check(v, 16'h0000);
    cmd(16'h0010); cyc(4);
    rd(1'b1, v); check(v, 16'h0001);
    rdr_ready = 1'b0; cyc(4);
    flag(status_irq, 1'b1);
    rd(1'b1, v); check(v, 16'h0000);
    final_report();
  end
endmodule : tb
